// >>> lcd_defines.svh
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH

// ====================================================================
// Register indices (byte address is four times the index)
`define LCD_IDX_TCLK 18'h05070
`define LCD_IDX_BCLK 18'h05071
`define LCD_IDX_DCTL 18'h050A0
`define LCD_IDX_CCTL 18'h050A2
`define LCD_IDX_VREG 18'h050A3
`define LCD_IDX_IMSK 18'h050A5
`define LCD_IDX_IFLG 18'h050A6

// ====================================================================
// Reset values
`define LCD_RST_TCLK 8'h00
`define LCD_RST_BCLK 8'h00
`define LCD_RST_DCTL 8'h10
`define LCD_RST_CCTL 8'h43
`define LCD_RST_VREG 8'h00
`define LCD_RST_IMSK 8'h00
`define LCD_RST_IFLG 8'h00

// ====================================================================
// Writable bit masks, reserved bits clear
`define LCD_MSK_TCLK 8'h3D
`define LCD_MSK_BCLK 8'h7D
`define LCD_MSK_DCTL 8'h13
`define LCD_MSK_CCTL 8'hC7
`define LCD_MSK_VREG 8'h11
`define LCD_MSK_IMSK 8'h01
`define LCD_MSK_IFLG 8'h01

// ====================================================================
// Field positions
`define LCD_GATE_BIT 0
`define LCD_SRC_HI 3
`define LCD_SRC_LO 2
`define LCD_TDIV_HI 5
`define LCD_TDIV_LO 4
`define LCD_BDIV_HI 6
`define LCD_BDIV_LO 4
`define LCD_REV_BIT 4
`define LCD_DSP_HI 1
`define LCD_DSP_LO 0
`define LCD_FRM_HI 7
`define LCD_FRM_LO 6
`define LCD_DUTY_HI 2
`define LCD_DUTY_LO 0
`define LCD_HVLD_BIT 4
`define LCD_REGULATOR_REFERENCE_SEL_BIT 0
`define LCD_FLAG_BIT 0

// ====================================================================
// Source codes and divider taps (counter bit k divides by 2^(k+1))
`define LCD_SRC_FIRST 2'h0
`define LCD_SRC_SECOND 2'h1
`define LCD_T_FIRST_TAP 4'h9
`define LCD_T_SECOND_TAP 4'h5
`define LCD_B_FIRST_TAP 4'h5
`define LCD_B_SECOND_TAP 4'h2
`define LCD_B_SECOND_MAX 3'h3
`define LCD_DIV_W 13
`define LCD_FRM_STEP 4'h4

`endif

// >>> lcd_pkg.sv
package lcd_pkg;

   // =================================================================
   // Register select
   typedef enum logic [2:0] {
      LCD_SEL_TCLK,
      LCD_SEL_BCLK,
      LCD_SEL_DCTL,
      LCD_SEL_CCTL,
      LCD_SEL_VREG,
      LCD_SEL_IMSK,
      LCD_SEL_IFLG,
      LCD_SEL_NONE
   } lcd_sel_t;

   // =================================================================
   // Panel-side controls
   typedef struct packed {
      logic lcd_timing_clk;
      logic booster_clk;
      logic frame_pulse;
      logic frame_irq;
      logic [1:0] display_mode_sel;
      logic reverse_pattern_ctrl;
      logic [2:0] common_duty_sel;
      logic regulator_heavy_load_mode;
      logic regulator_reference_sel;
   } lcd_out_t;

   // =================================================================
   // Whole state of the block
   typedef struct packed {
      logic [7:0] tclk_reg;
      logic [7:0] bclk_reg;
      logic [7:0] dctl;
      logic [7:0] cctl;
      logic [7:0] vreg;
      logic [7:0] imsk;
      logic [7:0] iflg;
      logic [2:0] osc1_sync;
      logic [2:0] osc2_sync;
      logic [12:0] tcnt;
      logic [12:0] bcnt;
      logic [3:0] fcnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      lcd_out_t out;
   } lcd_state_t;

endpackage : lcd_pkg

// >>> lcd_clk_frame.sv
`include "lcd_defines.svh"

// Operation
// - Timing clock source: code 0 first, 1 second
// - Timing clock divided by two-bit ratio field on first source; second source fixed at 1/64
// - Timing clock runs only while gate set
// - Booster clock source: code 0 first, 1 second
// - Booster clock divided by three-bit ratio field; second source capped at 1/64
// - Booster clock runs only while gate set
// - Display mode: off, normal, all on, all off
// - Reverse bit zero inverts the pattern
// - Frame divides base clock by 4/8/12/16
// - Duty select static, 1/2, 1/3, 1/4
// - Regulator heavy-load and reference select bits
// - Frame sets flag; writing one clears it
// - Interrupt forwarded only while enable set
module lcd_clk_frame (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic first_oscillator,
   input wire logic second_oscillator,
   output lcd_pkg::lcd_out_t lcd_ctl
);

   // =================================================================
   // Decode and helpers
   function automatic lcd_pkg::lcd_sel_t decode(input logic [19:0] a);
      lcd_pkg::lcd_sel_t r;
      r = lcd_pkg::LCD_SEL_NONE;
      if (a[1:0] != 2'h0) begin
         r = lcd_pkg::LCD_SEL_NONE;
      end else if (a[19:2] == `LCD_IDX_TCLK) begin
         r = lcd_pkg::LCD_SEL_TCLK;
      end else if (a[19:2] == `LCD_IDX_BCLK) begin
         r = lcd_pkg::LCD_SEL_BCLK;
      end else if (a[19:2] == `LCD_IDX_DCTL) begin
         r = lcd_pkg::LCD_SEL_DCTL;
      end else if (a[19:2] == `LCD_IDX_CCTL) begin
         r = lcd_pkg::LCD_SEL_CCTL;
      end else if (a[19:2] == `LCD_IDX_VREG) begin
         r = lcd_pkg::LCD_SEL_VREG;
      end else if (a[19:2] == `LCD_IDX_IMSK) begin
         r = lcd_pkg::LCD_SEL_IMSK;
      end else if (a[19:2] == `LCD_IDX_IFLG) begin
         r = lcd_pkg::LCD_SEL_IFLG;
      end
      return r;
   endfunction : decode

   // Edge of the selected source; reserved codes give no clock
   function automatic logic src_edge(input logic [1:0] code,
                                     input logic e1,
                                     input logic e2);
      logic r;
      r = 1'b0;
      if (code == `LCD_SRC_FIRST) begin
         r = e1;
      end else if (code == `LCD_SRC_SECOND) begin
         r = e2;
      end
      return r;
   endfunction : src_edge

   lcd_pkg::lcd_state_t s;
   lcd_pkg::lcd_state_t next_s;

   lcd_pkg::lcd_sel_t sel;
   logic e1;
   logic e2;
   logic t_edge;
   logic b_edge;
   logic [3:0] t_tap;
   logic [3:0] b_tap;
   logic next_tclk;
   logic next_bclk;
   logic base_rise;
   logic [3:0] frm_last;
   logic frame_evt;
   logic flag_clr;
   logic [7:0] rd;
   logic [7:0] wd;
   logic wr_en;

   // =================================================================
   // Next-state logic
   always_comb begin
      next_s = s;
      next_s.out.frame_pulse = 1'b0;
      flag_clr = 1'b0;
      rd = 8'h00;
      wd = pwdata[7:0];
      sel = decode(paddr);
      wr_en = 1'b0;

      // Oscillators are foreign: two flops, then a history flop for edges
      next_s.osc1_sync = {s.osc1_sync[1:0], first_oscillator};
      next_s.osc2_sync = {s.osc2_sync[1:0], second_oscillator};
      e1 = s.osc1_sync[1] & ~s.osc1_sync[2];
      e2 = s.osc2_sync[1] & ~s.osc2_sync[2];

      // Register read mux
      case (sel)
         lcd_pkg::LCD_SEL_TCLK: rd = s.tclk_reg;
         lcd_pkg::LCD_SEL_BCLK: rd = s.bclk_reg;
         lcd_pkg::LCD_SEL_DCTL: rd = s.dctl;
         lcd_pkg::LCD_SEL_CCTL: rd = s.cctl;
         lcd_pkg::LCD_SEL_VREG: rd = s.vreg;
         lcd_pkg::LCD_SEL_IMSK: rd = s.imsk;
         lcd_pkg::LCD_SEL_IFLG: rd = s.iflg;
         default: rd = 8'h00;
      endcase

      // APB: answer is prepared in setup, so access never waits
      if (psel && !penable) begin
         next_s.pready = 1'b1;
         next_s.pslverr = (sel == lcd_pkg::LCD_SEL_NONE);
         next_s.prdata = pwrite ? 32'h00000000 : {24'h000000, rd};
      end else if (psel && penable && s.pready) begin
         next_s.pready = 1'b0;
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h00000000;
         wr_en = pwrite && pstrb[0];
      end else begin
         next_s.pready = 1'b0;
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h00000000;
      end

      // Register writes; masks keep reserved bits at zero
      if (wr_en) begin
         case (sel)
            lcd_pkg::LCD_SEL_TCLK: next_s.tclk_reg = wd & `LCD_MSK_TCLK;
            lcd_pkg::LCD_SEL_BCLK: next_s.bclk_reg = wd & `LCD_MSK_BCLK;
            lcd_pkg::LCD_SEL_DCTL: next_s.dctl = wd & `LCD_MSK_DCTL;
            lcd_pkg::LCD_SEL_CCTL: next_s.cctl = wd & `LCD_MSK_CCTL;
            lcd_pkg::LCD_SEL_VREG: next_s.vreg = wd & `LCD_MSK_VREG;
            lcd_pkg::LCD_SEL_IMSK: next_s.imsk = wd & `LCD_MSK_IMSK;
            lcd_pkg::LCD_SEL_IFLG: flag_clr = wd[`LCD_FLAG_BIT];
            default: flag_clr = 1'b0;
         endcase
      end

      // Timing clock: source select, divider tap, gate
      t_edge = src_edge(s.tclk_reg[`LCD_SRC_HI:`LCD_SRC_LO], e1, e2);
      if (s.tclk_reg[`LCD_SRC_HI:`LCD_SRC_LO] == `LCD_SRC_SECOND) begin
         t_tap = `LCD_T_SECOND_TAP;
      end else begin
         t_tap = `LCD_T_FIRST_TAP
            + {2'h0, s.tclk_reg[`LCD_TDIV_HI:`LCD_TDIV_LO]};
      end
      if (!s.tclk_reg[`LCD_GATE_BIT]) begin
         next_s.tcnt = '0;
      end else if (t_edge) begin
         next_s.tcnt = s.tcnt + 13'h0001;
      end
      next_tclk = s.tclk_reg[`LCD_GATE_BIT] & next_s.tcnt[t_tap];
      next_s.out.lcd_timing_clk = next_tclk;

      // Booster clock; second source tops out at the 1/64 tap
      b_edge = src_edge(s.bclk_reg[`LCD_SRC_HI:`LCD_SRC_LO], e1, e2);
      if (s.bclk_reg[`LCD_SRC_HI:`LCD_SRC_LO] == `LCD_SRC_SECOND) begin
         if (s.bclk_reg[`LCD_BDIV_HI:`LCD_BDIV_LO] > `LCD_B_SECOND_MAX) begin
            b_tap = `LCD_B_SECOND_TAP + {1'b0, `LCD_B_SECOND_MAX};
         end else begin
            b_tap = `LCD_B_SECOND_TAP
               + {1'b0, s.bclk_reg[`LCD_BDIV_HI:`LCD_BDIV_LO]};
         end
      end else begin
         b_tap = `LCD_B_FIRST_TAP
            + {1'b0, s.bclk_reg[`LCD_BDIV_HI:`LCD_BDIV_LO]};
      end
      if (!s.bclk_reg[`LCD_GATE_BIT]) begin
         next_s.bcnt = '0;
      end else if (b_edge) begin
         next_s.bcnt = s.bcnt + 13'h0001;
      end
      next_bclk = s.bclk_reg[`LCD_GATE_BIT] & next_s.bcnt[b_tap];
      next_s.out.booster_clk = next_bclk;

      // Frame: count base clock rises, period 4*(code+1)
      base_rise = next_tclk & ~s.out.lcd_timing_clk;
      frm_last = `LCD_FRM_STEP
         * ({2'h0, s.cctl[`LCD_FRM_HI:`LCD_FRM_LO]} + 4'h1)
         - 4'h1;
      frame_evt = 1'b0;
      if (!s.tclk_reg[`LCD_GATE_BIT]) begin
         next_s.fcnt = 4'h0;
      end else if (base_rise) begin
         if (s.fcnt >= frm_last) begin
            next_s.fcnt = 4'h0;
            frame_evt = 1'b1;
         end else begin
            next_s.fcnt = s.fcnt + 4'h1;
         end
      end
      next_s.out.frame_pulse = frame_evt;

      // A frame arriving with a clear still sets the flag
      next_s.iflg[`LCD_FLAG_BIT] = (s.iflg[`LCD_FLAG_BIT] & ~flag_clr)
         | frame_evt;
      next_s.out.frame_irq = next_s.iflg[`LCD_FLAG_BIT]
         & next_s.imsk[`LCD_FLAG_BIT];

      // Static panel controls follow the registers
      next_s.out.display_mode_sel =
         next_s.dctl[`LCD_DSP_HI:`LCD_DSP_LO];
      next_s.out.reverse_pattern_ctrl = next_s.dctl[`LCD_REV_BIT];
      next_s.out.common_duty_sel =
         next_s.cctl[`LCD_DUTY_HI:`LCD_DUTY_LO];
      next_s.out.regulator_heavy_load_mode =
         next_s.vreg[`LCD_HVLD_BIT];
      next_s.out.regulator_reference_sel =
         next_s.vreg[`LCD_REGULATOR_REFERENCE_SEL_BIT];
   end

   // =================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.tclk_reg <= `LCD_RST_TCLK;
         s.bclk_reg <= `LCD_RST_BCLK;
         s.dctl <= `LCD_RST_DCTL;
         s.cctl <= `LCD_RST_CCTL;
         s.vreg <= `LCD_RST_VREG;
         s.imsk <= `LCD_RST_IMSK;
         s.iflg <= `LCD_RST_IFLG;
         s.out.reverse_pattern_ctrl <= 1'b1;
         s.out.common_duty_sel <= 3'h3;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign lcd_ctl = s.out;

endmodule : lcd_clk_frame

// >>> lcd_osc_model.sv
module lcd_osc_model (
   output logic first_oscillator,
   output logic second_oscillator
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================================
   // Free-running oscillators, offset so no edge meets pclk
   initial begin
      first_oscillator = 1'b0;
      #3;
      forever #60 first_oscillator = ~first_oscillator;
   end
   initial begin
      second_oscillator = 1'b0;
      #7;
      forever #50 second_oscillator = ~second_oscillator;
   end
endmodule : lcd_osc_model

// >>> lcd_clk_frame_assertions.sv
module lcd_clk_frame_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire lcd_pkg::lcd_out_t lcd_ctl
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =========================================================
   // Shadow gates, tracked from completed writes
   logic acc;
   logic tg;
   logic bg;
   logic en;
   assign acc = psel && penable && pready && pwrite && pstrb[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tg <= 1'b0;
         bg <= 1'b0;
         en <= 1'b0;
      end else if (acc) begin
         if (paddr == 20'h141C0) tg <= pwdata[0];
         if (paddr == 20'h141C4) bg <= pwdata[0];
         if (paddr == 20'h14294) en <= pwdata[0];
      end
   end
   chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_tclk_gated: assert property (!tg ##1 !tg |-> !lcd_ctl.lcd_timing_clk)
      else $error("timing clock runs while gated");
   chk_bclk_gated: assert property (!bg ##1 !bg |-> !lcd_ctl.booster_clk)
      else $error("booster clock runs while gated");
   chk_irq_masked: assert property (!en ##1 !en |-> !lcd_ctl.frame_irq)
      else $error("frame irq while disabled");
   chk_flag_sets: assert property (lcd_ctl.frame_pulse && en |-> ##[0:1] lcd_ctl.frame_irq)
      else $error("frame did not raise irq");
   chk_display_mirror: assert property (acc && paddr == 20'h14280 |=> ##1
      lcd_ctl.display_mode_sel == $past(pwdata[1:0], 2)
      && lcd_ctl.reverse_pattern_ctrl == $past(pwdata[4], 2))
      else $error("display control not applied");
   chk_duty_mirror: assert property (acc && paddr == 20'h14288 |=> ##1
      lcd_ctl.common_duty_sel == $past(pwdata[2:0], 2))
      else $error("duty not applied");
   chk_vreg_mirror: assert property (acc && paddr == 20'h1428C |=> ##1
      lcd_ctl.regulator_heavy_load_mode == $past(pwdata[4], 2)
      && lcd_ctl.regulator_reference_sel == $past(pwdata[0], 2))
      else $error("regulator bits not applied");
   cover property (lcd_ctl.frame_pulse && en);
   cover property ($rose(lcd_ctl.booster_clk));
   cover property ($rose(lcd_ctl.lcd_timing_clk));
endmodule : lcd_clk_frame_chk

bind lcd_clk_frame lcd_clk_frame_chk i_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .lcd_ctl);

// >>> tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oa, ob, err;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   lcd_pkg::lcd_out_t ctl;
   int miscompares, checks_done, cyc, n;
   logic [19:0] adr [7] = '{20'h141C0, 20'h141C4, 20'h14280, 20'h14288,
      20'h1428C, 20'h14294, 20'h14298};
   logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h10, 8'h43, 8'h00, 8'h00, 8'h00};
   logic [7:0] msk [7] = '{8'h3D, 8'h7D, 8'h13, 8'hC7, 8'h11, 8'h01, 8'h00};
   lcd_osc_model i_osc (.first_oscillator(oa), .second_oscillator(ob));
   lcd_clk_frame i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_oscillator(oa), .second_oscillator(ob), .lcd_ctl(ctl));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk(logic [31:0] seen, logic [31:0] exp, string nm);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic near(int c, int e, string nm);
      chk(32'((c >= e - 2 && c <= e + 2) ? e : c), 32'(e), nm);
   endtask : near
   // =========================================================
   // APB transfer: request held until pready is sampled high
   task automatic apb(logic w, logic [19:0] a, logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at pready while it settles before the edge that samples it
      do @(negedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(logic [19:0] a, logic [7:0] e, string nm);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h0, e}, nm);
   endtask : rdchk
   function automatic logic sig(int k);
      return k == 0 ? ctl.lcd_timing_clk :
         k == 1 ? ctl.booster_clk : ctl.frame_pulse;
   endfunction : sig
   // Counts pclk cycles of one full period, rise to rise
   task automatic meas(int k, output int c);
      do @(posedge pclk); while (sig(k) !== 1'b0);
      do @(posedge pclk); while (sig(k) !== 1'b1);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (sig(k) !== 1'b0);
      do begin
         @(posedge pclk);
         c++;
      end while (sig(k) !== 1'b1);
   endtask : meas
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 20'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      {miscompares, checks_done, cyc} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(ctl.common_duty_sel, 32'h3, "duty rst");
      chk(ctl.reverse_pattern_ctrl, 32'h1, "rev rst");
      for (int i = 0; i < 7; i++)
         rdchk(adr[i], rst[i], "reset");
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, adr[i], 8'hFF);
         rdchk(adr[i], msk[i], "mask");
      end
      apb(1'b0, 20'h14284, 8'h00);
      chk(err, 32'h1, "slverr");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, adr[2], 8'(m));
         apb(1'b1, adr[3], 8'(m * 64 + m));
         apb(1'b1, adr[4], 8'((m & 2) * 8 + (m & 1)));
         @(posedge pclk);
         chk(ctl.display_mode_sel, 32'(m), "mode");
         chk(ctl.reverse_pattern_ctrl, 32'h0, "rev");
         chk(ctl.common_duty_sel, 32'(m), "duty");
         chk(ctl.regulator_heavy_load_mode, 32'(m / 2), "hvy");
         chk(ctl.regulator_reference_sel, 32'(m % 2), "ref");
      end
      apb(1'b1, adr[0], 8'h05);
      meas(0, n);
      near(n, 64 * 5, "tclk b");
      apb(1'b1, adr[5], 8'h01);
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, adr[3], 8'(f * 64 + 3));
         meas(2, n);
         near(n, 4 * (f + 1) * 320, "frame");
      end
      @(posedge pclk);
      chk(ctl.frame_irq, 32'h1, "irq");
      apb(1'b1, adr[6], 8'h00);
      rdchk(adr[6], 8'h01, "flag keep");
      apb(1'b1, adr[6], 8'h01);
      rdchk(adr[6], 8'h00, "flag clr");
      apb(1'b1, adr[5], 8'h00);
      meas(2, n);
      @(posedge pclk);
      chk(ctl.frame_irq, 32'h0, "masked");
      rdchk(adr[6], 8'h01, "flag set");
      apb(1'b1, adr[0], 8'h01);
      meas(0, n);
      near(n, 1024 * 6, "tclk a");
      apb(1'b1, adr[0], 8'h00);
      for (int b = 0; b < 4; b++) begin
         apb(1'b1, adr[1], 8'(b * 16 + 5));
         meas(1, n);
         near(n, (8 << b) * 5, "bclk b");
      end
      apb(1'b1, adr[1], 8'h01);
      meas(1, n);
      near(n, 64 * 6, "bclk a");
      summarize();
   end
endmodule : tb_top
